/* File: rtl/dsr_readout.sv */
/*
  Digital side of an oversampling converter: sync/power-down sequencing,
  three-stage decimating filter, settling timer, ready flag and serial
  shift-out with chain input.
  Assumes all pins are asynchronous to clk and toggle well below clk/4,
  and that the converter core supplies rawSample on the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

`include "dsr_defs.svh"

module dsr_readout #(
  parameter int FIRST_DECIM = 8,
  parameter int EXTRA_CYC   = `DSR_EXTRA_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire dsr_pkg::dsr_pins_s pins,
  input  wire dsr_pkg::dsr_word_t rawSample,
  output logic                   sampleStrobe,
  output logic                   coreActive,
  output logic                   resultValidN,
  output dsr_pkg::dsr_sout_s     sout
);
  import dsr_pkg::*;

  localparam int W           = `DSR_RESULT_W;
  // rate is conversion clock over TOTAL_DECIM
  localparam int TOTAL_DECIM = FIRST_DECIM * `DSR_LATER_FACTOR * `DSR_LATER_FACTOR;

  function automatic int settleFor(input int decim);
    if (decim <= 8) begin
      return `DSR_SETTLE_D8;
    end else if (decim <= 16) begin
      return `DSR_SETTLE_D16;
    end
    return `DSR_SETTLE_D32;
  endfunction : settleFor

  localparam int SETTLE_N = settleFor(TOTAL_DECIM);
  localparam int SCW      = $clog2(SETTLE_N + 1);
  localparam int ECW      = $clog2(EXTRA_CYC + 1);

  // Pin synchronisers
  logic convRise;
  logic csLevel;
  logic csFall;
  logic syncLevel;
  logic shiftRise;
  logic shiftFall;
  logic chainLevel;

  dsr_sync u_conv (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (pins.convClk),
    .resetVal (1'b0),
    .level    (),
    .rise     (convRise),
    .fall     ()
  );

  dsr_sync u_cs (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (pins.csN),
    .resetVal (1'b1),
    .level    (csLevel),
    .rise     (),
    .fall     (csFall)
  );

  dsr_sync u_syncpd (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (pins.syncPowerdownN),
    .resetVal (1'b1),
    .level    (syncLevel),
    .rise     (),
    .fall     ()
  );

  dsr_sync u_shift (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (pins.shiftClk),
    .resetVal (1'b0),
    .level    (),
    .rise     (shiftRise),
    .fall     (shiftFall)
  );

  dsr_sync u_chain (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (pins.chainIn),
    .resetVal (1'b0),
    .level    (chainLevel),
    .rise     (),
    .fall     ()
  );

  // Power and reset sequencing, all on conversion-clock rising edges
  dsr_power_e power_reg;
  dsr_power_e power_next;

  always_comb begin
    power_next = power_reg;
    if (convRise) begin
      if (!syncLevel) begin
        power_next = PS_DOWN;
      end else begin
        unique case (power_reg)
          PS_DOWN:   power_next = PS_WAKE;
          PS_WAKE:   power_next = PS_FRESET;
          PS_FRESET: power_next = PS_RUN;
          PS_RUN:    power_next = PS_RUN;
        endcase
      end
    end
  end

  // sequence depends only on shared pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_reg <= PS_DOWN;
    end else begin
      power_reg <= power_next;
    end
  end

  assign coreActive = (power_reg != PS_DOWN);

  // one raw sample per conversion edge
  // conversion timing uses the conversion clock only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= convRise && (power_reg == PS_RUN || power_reg == PS_FRESET)
                      && syncLevel;
    end
  end

  logic      sampleTake_reg;
  dsr_word_t sampleData_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampleTake_reg <= 1'b0;
      sampleData_reg <= '0;
    end else begin
      sampleTake_reg <= sampleStrobe;
      if (sampleStrobe) begin
        sampleData_reg <= rawSample;
      end
    end
  end

  logic      filterClear;
  logic      s1Valid;
  logic      s2Valid;
  logic      filtValid;
  dsr_word_t s1Data;
  dsr_word_t s2Data;
  dsr_word_t filtData;

  // Filter history is dropped while down and waking, up to the reset edge
  assign filterClear = (power_reg == PS_DOWN) || (power_reg == PS_WAKE);

  dsr_dec_stage #(.W(W), .FACTOR(FIRST_DECIM)) u_stage1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (filterClear),
    .inValid  (sampleTake_reg),
    .inData   (sampleData_reg),
    .outValid (s1Valid),
    .outData  (s1Data)
  );

  dsr_dec_stage #(.W(W), .FACTOR(`DSR_LATER_FACTOR)) u_stage2 (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (filterClear),
    .inValid  (s1Valid),
    .inData   (s1Data),
    .outValid (s2Valid),
    .outData  (s2Data)
  );

  dsr_dec_stage #(.W(W), .FACTOR(`DSR_LATER_FACTOR)) u_stage3 (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (filterClear),
    .inValid  (s2Valid),
    .inData   (s2Data),
    .outValid (filtValid),
    .outData  (filtData)
  );

  // settling counted from the wake edge
  logic [SCW-1:0] settleCnt_reg;
  logic           settled_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || power_reg == PS_DOWN) begin
      settleCnt_reg <= '0;
      settled_reg   <= 1'b0;
    end else if (convRise && syncLevel && !settled_reg) begin
      if (settleCnt_reg == SCW'(SETTLE_N - 1)) begin
        settled_reg <= 1'b1;
      end
      settleCnt_reg <= settleCnt_reg + SCW'(1);
    end
  end

  // Fixed extra delay after the counted edges
  logic [ECW-1:0] extraCnt_reg;
  logic           extraDone_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || !settled_reg) begin
      extraCnt_reg  <= '0;
      extraDone_reg <= 1'b0;
    end else if (!extraDone_reg) begin
      if (extraCnt_reg == ECW'(EXTRA_CYC - 1)) begin
        extraDone_reg <= 1'b1;
      end
      extraCnt_reg <= extraCnt_reg + ECW'(1);
    end
  end

  // Live once the first result has been published
  logic      live_reg;
  logic      firstPublish;
  logic      publish;
  dsr_word_t latest_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || power_reg == PS_DOWN) begin
      latest_reg <= '0;
    end else if (filtValid) begin
      latest_reg <= filtData;
    end
  end

  assign firstPublish = extraDone_reg && !live_reg;
  assign publish = firstPublish || (live_reg && filtValid);

  always_ff @(posedge clk) begin
    if (!rst_n || power_reg == PS_DOWN) begin
      live_reg <= 1'b0;
    end else if (firstPublish) begin
      live_reg <= 1'b1;
    end
  end

  // Ready flag: one high cycle while the output word updates, then low
  logic      loadPend_reg;
  dsr_word_t pend_reg;
  dsr_word_t outWord_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resultValidN <= 1'b1;
      loadPend_reg <= 1'b0;
      pend_reg     <= '0;
      outWord_reg  <= '0;
    end else if (power_reg == PS_DOWN || (convRise && !syncLevel)) begin
      resultValidN <= 1'b1;
      loadPend_reg <= 1'b0;
    end else if (publish) begin
      resultValidN <= 1'b1;
      loadPend_reg <= 1'b1;
      pend_reg     <= firstPublish ? (filtValid ? filtData : latest_reg) : filtData;
    end else if (loadPend_reg) begin
      resultValidN <= 1'b0;
      loadPend_reg <= 1'b0;
      outWord_reg  <= pend_reg;
    end
  end

  // Serial shifter; chain bit captured on the shift-clock rising edge
  dsr_word_t shift_reg;
  logic      chainBit_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chainBit_reg <= 1'b0;
    end else if (shiftRise && !csLevel) begin
      chainBit_reg <= chainLevel;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (loadPend_reg) begin
      shift_reg <= pend_reg;
    end else if (csFall) begin
      shift_reg <= outWord_reg;
    end else if (shiftFall && !csLevel) begin
      shift_reg <= {shift_reg[W-2:0], chainBit_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sout.serialOut   <= 1'b0;
      sout.serialOutEn <= 1'b0;
    end else begin
      sout.serialOut   <= shift_reg[W-1];
      sout.serialOutEn <= !csLevel;
    end
  end


endmodule : dsr_readout

`default_nettype wire

/* File: rtl/dsr_defs.svh */
/*
  Constants for the decimating converter serial readout: widths, settling
  counts and timing. Assumes a single 25 MHz system clock samples all pins.
*/
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

`define DSR_RESULT_W       24
`define DSR_SETTLE_D8      594
`define DSR_SETTLE_D16     1186
`define DSR_SETTLE_D32     2370
`define DSR_CLK_PERIOD_NS  40
`define DSR_EXTRA_NS       200
`define DSR_EXTRA_CYC      ((`DSR_EXTRA_NS + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_LATER_FACTOR   2

`endif

/* File: rtl/dsr_pkg.sv */
/*
  Types for the decimating converter serial readout.
  Assumes dsr_defs.svh is reachable by bare name.
*/
`include "dsr_defs.svh"

package dsr_pkg;

  // Raw input pins, all asynchronous to clk
  typedef struct packed {
    logic convClk;
    logic csN;
    logic syncPowerdownN;
    logic shiftClk;
    logic chainIn;
  } dsr_pins_s;

  // Tristate serial output: level and enable
  typedef struct packed {
    logic serialOut;
    logic serialOutEn;
  } dsr_sout_s;

  typedef enum logic [1:0] {
    PS_DOWN   = 2'b00,
    PS_WAKE   = 2'b01,
    PS_FRESET = 2'b10,
    PS_RUN    = 2'b11
  } dsr_power_e;

  typedef logic [`DSR_RESULT_W-1:0] dsr_word_t;

endpackage : dsr_pkg

/* File: rtl/dsr_sync.sv */
/*
  Two-flop synchroniser with edge pulses for one asynchronous pin.
  Assumes clk is free running; edges are detected after the second flop.
*/
`timescale 1ns/1ps
`default_nettype none

module dsr_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  input  wire logic resetVal,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;
  logic stable_reg;
  logic prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg   <= 1'b0;
      stable_reg <= 1'b0;
      prev_reg   <= 1'b0;
    end else begin
      meta_reg   <= pinIn;
      stable_reg <= meta_reg;
      prev_reg   <= stable_reg;
    end
  end

  // Reset value stands in for the level, and edges are masked, until the chain has filled with real data
  logic [1:0] fill_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill_reg <= 2'h0;
    end else if (fill_reg != 2'h3) begin
      fill_reg <= fill_reg + 2'h1;
    end
  end

  assign level = (fill_reg == 2'h3) ? stable_reg : resetVal;
  assign rise  = (fill_reg == 2'h3) & stable_reg & ~prev_reg;
  assign fall  = (fill_reg == 2'h3) & ~stable_reg & prev_reg;

endmodule : dsr_sync

`default_nettype wire

/* File: rtl/dsr_dec_stage.sv */
/*
  One decimating filter stage: boxcar average of FACTOR inputs.
  Assumes FACTOR is a power of two and inputs arrive as one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module dsr_dec_stage #(
  parameter int W      = 24,
  parameter int FACTOR = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  output logic [W-1:0]      outData
);
  localparam int SH = $clog2(FACTOR);

  logic signed [W+SH-1:0] acc_reg;
  logic        [SH-1:0]   cnt_reg;
  logic signed [W+SH-1:0] sum;

  assign sum = acc_reg + (W+SH)'(signed'(inData));

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      acc_reg  <= '0;
      cnt_reg  <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      outValid <= 1'b0;
      if (inValid) begin
        if (cnt_reg == SH'(FACTOR - 1)) begin
          // Dividing by shift keeps the stage gain at one
          outData  <= W'(sum >>> SH);
          outValid <= 1'b1;
          acc_reg  <= '0;
          cnt_reg  <= '0;
        end else begin
          acc_reg <= sum;
          cnt_reg <= cnt_reg + SH'(1);
        end
      end
    end
  end

endmodule : dsr_dec_stage

`default_nettype wire

/* File: testbench/dsr_readout_checker.sv */
/* Port checker for dsr_readout.
   Bound into the design; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dsr_readout_checker #(
  parameter int FIRST_DECIM = 8,
  parameter int EXTRA_CYC   = 1
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire dsr_pkg::dsr_pins_s pins,
  input wire logic               sampleStrobe,
  input wire logic               coreActive,
  input wire logic               resultValidN,
  input wire dsr_pkg::dsr_sout_s sout
);
  import dsr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_cs_high_float: assert property (pins.csN [*5] |-> !sout.serialOutEn)
    else $error("output driven while deselected");
  a_cs_low_drive: assert property ((!pins.csN) [*5] |-> sout.serialOutEn)
    else $error("output idle while selected");
  a_sync_powers_down: assert property (
    (!pins.syncPowerdownN) [*5] ##0 $rose(pins.convClk) |-> ##[1:6] (resultValidN && !coreActive))
    else $error("sync low did not power down");
  a_down_ready_high: assert property (!coreActive |-> resultValidN)
    else $error("ready low while powered down");
  a_down_no_strobe: assert property (!coreActive |-> !sampleStrobe)
    else $error("sample taken while powered down");
  a_strobe_single: assert property (sampleStrobe |=> (!sampleStrobe) [*6])
    else $error("sample strobe too long");
  a_strobe_per_rise: assert property (
    (pins.syncPowerdownN && !resultValidN) [*5] ##0 $rose(pins.convClk) |-> ##[1:6] sampleStrobe)
    else $error("conversion edge gave no sample");
  a_update_pulse: assert property (
    pins.syncPowerdownN [*8] ##0 $rose(resultValidN) |=> $fell(resultValidN))
    else $error("ready high too long at update");
  a_out_quiet: assert property (
    (pins.syncPowerdownN && !resultValidN && !pins.csN && $stable(pins.shiftClk)) [*8]
    |-> $stable(sout.serialOut))
    else $error("serial data moved without shift clock");
endmodule : dsr_readout_checker
bind dsr_readout dsr_readout_checker #(.FIRST_DECIM(FIRST_DECIM), .EXTRA_CYC(EXTRA_CYC)) chk_inst (
  .clk(clk), .rst_n(rst_n), .pins(pins), .sampleStrobe(sampleStrobe),
  .coreActive(coreActive), .resultValidN(resultValidN), .sout(sout));
`default_nettype wire

/* File: testbench/dsr_host_model.sv */
/* Host model: conversion clock, sync pulses, serial reads.
   Assumes callers act at falling clk edges. */
`timescale 1ns/1ps
`default_nettype none
module dsr_host_model #(
  parameter int HALF = 32,
  parameter int PH   = 6
) (
  input  wire logic               clk,
  input  wire logic               resultValidN,
  input  wire dsr_pkg::dsr_sout_s sout,
  output var  dsr_pkg::dsr_pins_s pins
);
  import dsr_pkg::*;
  int convRises = 0;
  int cyc       = 0;
  int phase     = 0;
  initial pins = 5'h0C;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) begin
    phase <= (phase == HALF - 1) ? 0 : phase + 1;
    if (phase == HALF - 1) begin
      pins.convClk <= !pins.convClk;
      convRises    <= convRises + (pins.convClk ? 0 : 1);
    end
  end
  task automatic syncPulse(input int lowCyc);
    pins.syncPowerdownN = 1'b0;
    repeat (lowCyc) @(negedge clk);
    while (pins.convClk || phase != HALF / 2) @(negedge clk);
    pins.syncPowerdownN = 1'b1;
  endtask : syncPulse
  task automatic setCs(input logic v);
    pins.csN = v;
  endtask : setCs
  task automatic readBits(input int n, input logic [31:0] chain, output logic [31:0] w);
    w = '0;
    while (resultValidN) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      pins.chainIn = chain[31-i];
      repeat (PH) @(negedge clk);
      // A released line reads as the inverse so a read while floating shows up
      w = {w[30:0], sout.serialOutEn ? sout.serialOut : !sout.serialOut};
      pins.shiftClk = 1'b1;
      repeat (PH) @(negedge clk);
      pins.shiftClk = 1'b0;
    end
    pins.chainIn = 1'b0;
  endtask : readBits
endmodule : dsr_host_model
`default_nettype wire

/* File: testbench/tb.sv */
/* Bench for dsr_readout: settling, output period, both read modes, chain data.
   Assumes the rtl package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsr_pkg::*;
  localparam int        HALF  = 32;
  localparam int        CP    = 2 * HALF;
  localparam int        EXTRA = 1;
  localparam dsr_word_t C1    = 24'hA5C396;
  localparam dsr_word_t C2    = 24'h3F0A5C;
  localparam logic [7:0] CHAIN = 8'hB4;
  logic      clk;
  logic      rst_n;
  dsr_pins_s pins;
  dsr_word_t rawSample;
  logic      sampleStrobe;
  logic      coreActive;
  logic      resultValidN;
  dsr_sout_s sout;
  int        err_total = 0;
  int        cmp_count = 0;
  dsr_readout #(.FIRST_DECIM(2), .EXTRA_CYC(EXTRA)) dsr_readout_inst (
    .clk(clk), .rst_n(rst_n), .pins(pins), .rawSample(rawSample), .sampleStrobe(sampleStrobe),
    .coreActive(coreActive), .resultValidN(resultValidN), .sout(sout));
  dsr_host_model #(.HALF(HALF)) host (
    .clk(clk), .resultValidN(resultValidN), .sout(sout), .pins(pins));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkIn(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chkIn
  task automatic waitReady(input logic lvl, input int lim, output int n);
    n = 0;
    while (resultValidN !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : waitReady
  task automatic restart(input bit full);
    int r0;
    int t0;
    int n;
    host.syncPulse(3 * CP);
    chk("ready down", 1'b1, resultValidN);
    chk("core down", 1'b0, coreActive);
    r0 = host.convRises;
    while (host.convRises == r0) @(negedge clk);
    t0 = host.cyc;
    n = 0;
    while (sampleStrobe !== 1'b1 && n < 4 * CP) begin
      @(negedge clk);
      n++;
    end
    chk("edges to sample", 3, host.convRises - r0);
    chk("core awake", 1'b1, coreActive);
    chk("ready settling", 1'b1, resultValidN);
    if (full) begin
      waitReady(1'b0, 600 * CP, n);
      chkIn("settle", 594 * CP + EXTRA, 594 * CP + EXTRA + 12, host.cyc - t0);
    end
  endtask : restart
  task automatic steadyPeriod();
    int a;
    int b;
    waitReady(1'b1, 16 * CP, a);
    waitReady(1'b0, 8, a);
    waitReady(1'b1, 8 * CP, a);
    waitReady(1'b0, 8, b);
    chk("period", 8 * CP, a + b);
    chk("update gap", 1, b);
  endtask : steadyPeriod
  task automatic csRead();
    logic [31:0] w;
    chk("enable off", 1'b0, sout.serialOutEn);
    repeat (20) @(negedge clk);
    host.setCs(1'b0);
    host.readBits(32, {CHAIN, 24'h000000}, w);
    chk("enable on", 1'b1, sout.serialOutEn);
    host.setCs(1'b1);
    chk("word and chain", {C1, CHAIN}, w);
    // Select must be seen high before the next scenario lowers it again
    repeat (6) @(negedge clk);
    chk("enable off again", 1'b0, sout.serialOutEn);
  endtask : csRead
  task automatic threeWire();
    logic [31:0] w;
    int n;
    rawSample = C2;
    host.setCs(1'b0);
    repeat (4) begin
      waitReady(1'b1, 8 * CP, n);
      waitReady(1'b0, 8, n);
    end
    host.readBits(24, 32'h00000000, w);
    chk("three-wire word", C2, w[23:0]);
    host.setCs(1'b1);
  endtask : threeWire
  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  initial begin
    repeat (800 * CP) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    rawSample = C1;
    repeat (10) @(negedge clk);
    chk("reset ready", 1'b1, resultValidN);
    chk("reset enable", 1'b0, sout.serialOutEn);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    restart(1'b1);
    steadyPeriod();
    csRead();
    threeWire();
    restart(1'b0);
    results();
  end
endmodule : tb
`default_nettype wire
